// ==== core/tlvic_cfg.svh ====
// constants of the two-level vectored interrupt controller
// assumes the core drives the special register port and machine-cycle strobes
// Functional notes
// - usb request raised on endpoint traffic, suspend, resume and end-of-packet
// - each serial request is receive-complete or transmit-complete
// - second serial port like the first, controls at bit 4
// - each source has one level bit, 0 low, 1 high
// - high requests may preempt a low routine
// - a high routine blocks every other request until it ends
// - high level wins over low in the same poll
// - fixed polling order breaks ties within a level
// - each source gated by its own enable bit
// - global enable at bit 7 gates all sources
// - primary enable bit map, bit 6 reserved
// - secondary enable bit map, other bits unused
// - primary level bit map, bits 7 and 6 reserved
// - secondary level bit map, other bits unused
// - flags sampled once per machine cycle, polled next cycle, never remembered
// - call withheld for equal or higher routine, mid-instruction, return or register access
// - fixed vector address per source on acknowledge
`ifndef TLVIC_CFG_SVH
`define TLVIC_CFG_SVH
`define TLVIC_ADDR_SEC_EN   8'ha7
`define TLVIC_ADDR_PRI_EN   8'ha8
`define TLVIC_ADDR_SEC_LVL  8'hb7
`define TLVIC_ADDR_PRI_LVL  8'hb8
`define TLVIC_RESET_VAL     8'h00
`define TLVIC_MASK_PRI_EN   8'hbf
`define TLVIC_MASK_PRI_LVL  8'h3f
`define TLVIC_MASK_SEC      8'h93
`define TLVIC_GLOBAL_BIT    7
`define TLVIC_NUM_SRC       10
// source index = polling order, 0 highest
`define TLVIC_SRC_EXT0      0
`define TLVIC_SRC_SER2      1
`define TLVIC_SRC_TMR0      2
`define TLVIC_SRC_TWI       3
`define TLVIC_SRC_EXT1      4
`define TLVIC_SRC_DDC       5
`define TLVIC_SRC_TMR1      6
`define TLVIC_SRC_USB       7
`define TLVIC_SRC_SER1      8
`define TLVIC_SRC_TMR2      9
`define TLVIC_VEC_EXT0      16'h0003
`define TLVIC_VEC_SER2      16'h004b
`define TLVIC_VEC_TMR0      16'h000b
`define TLVIC_VEC_TWI       16'h0043
`define TLVIC_VEC_EXT1      16'h0013
`define TLVIC_VEC_DDC       16'h003b
`define TLVIC_VEC_TMR1      16'h001b
`define TLVIC_VEC_USB       16'h0033
`define TLVIC_VEC_SER1      16'h0023
`define TLVIC_VEC_TMR2      16'h002b
`endif

// ==== core/tlvic_pkg.sv ====
// types of the two-level vectored interrupt controller
// assumes tlvic_cfg.svh holds the numbers
package tlvic_pkg;
	typedef struct packed {
		logic [7:0]  sec_en;
		logic [7:0]  pri_en;
		logic [7:0]  sec_lvl;
		logic [7:0]  pri_lvl;
		logic [9:0]  sample;
		logic [1:0]  in_prog;
		logic        call;
		logic [15:0] vector;
		logic [3:0]  src;
		logic [7:0]  rdata;
	} tlvic_state_type;
endpackage

// ==== core/tlvic_ctrl.sv ====
// two-level vectored interrupt controller: registers, sampling, poll, vectoring
// assumes core gives a sample strobe once per machine cycle and a poll strobe
// in the next, and a final-cycle flag and a return pulse from its sequencer
`timescale 1ns/100ps
`include "tlvic_cfg.svh"
module tlvic_ctrl
	import tlvic_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic        sample_i,
	input  wire logic        poll_i,
	input  wire logic        final_cycle_i,
	input  wire logic        return_from_irq_i,
	input  wire logic        reg_access_i,
	input  wire logic        ext_pin0_request_i,
	input  wire logic        ext_pin1_request_i,
	input  wire logic        timer0_flag_i,
	input  wire logic        timer1_flag_i,
	input  wire logic        timer2_flag_i,
	input  wire logic        timer2_ext_flag_i,
	input  wire logic        ser1_rx_complete_flag_i,
	input  wire logic        ser1_tx_complete_flag_i,
	input  wire logic        ser2_rx_complete_flag_i,
	input  wire logic        ser2_tx_complete_flag_i,
	input  wire logic        twowire_flag_i,
	input  wire logic        display_data_channel_i,
	input  wire logic [5:0]  usb_event_i,
	output logic             long_call_o,
	output logic      [15:0] vector_o,
	output logic      [3:0]  src_o,
	output logic      [1:0]  in_prog_o
);
	tlvic_state_type st;
	tlvic_state_type next_st;
	logic [9:0]  raw;
	logic [9:0]  en_map;
	logic [9:0]  lvl_map;
	logic [9:0]  act;
	logic [9:0]  hi_req;
	logic [9:0]  lo_req;
	logic [15:0] vec_tab [0:9];

	// usb request: ep0 tx/rx, ep1 tx, ep2 tx, suspend/resume, eop
	// serial requests are or of rx and tx; timer2 includes its external flag
	always_comb
	begin
		raw = '0;
		raw[`TLVIC_SRC_EXT0] = ext_pin0_request_i;
		raw[`TLVIC_SRC_SER2] = ser2_rx_complete_flag_i | ser2_tx_complete_flag_i;
		raw[`TLVIC_SRC_TMR0] = timer0_flag_i;
		raw[`TLVIC_SRC_TWI]  = twowire_flag_i;
		raw[`TLVIC_SRC_EXT1] = ext_pin1_request_i;
		raw[`TLVIC_SRC_DDC]  = display_data_channel_i;
		raw[`TLVIC_SRC_TMR1] = timer1_flag_i;
		raw[`TLVIC_SRC_USB]  = |usb_event_i;
		raw[`TLVIC_SRC_SER1] = ser1_rx_complete_flag_i | ser1_tx_complete_flag_i;
		raw[`TLVIC_SRC_TMR2] = timer2_flag_i | timer2_ext_flag_i;
	end

	// register bits to poll order
	always_comb
	begin
		en_map = {st.pri_en[5], st.pri_en[4], st.sec_en[0], st.pri_en[3], st.sec_en[7],
			st.pri_en[2], st.sec_en[1], st.pri_en[1], st.sec_en[4], st.pri_en[0]};
		lvl_map = {st.pri_lvl[5], st.pri_lvl[4], st.sec_lvl[0], st.pri_lvl[3], st.sec_lvl[7],
			st.pri_lvl[2], st.sec_lvl[1], st.pri_lvl[1], st.sec_lvl[4], st.pri_lvl[0]};
	end

	// vector table in poll order
	assign vec_tab[0] = `TLVIC_VEC_EXT0;
	assign vec_tab[1] = `TLVIC_VEC_SER2;
	assign vec_tab[2] = `TLVIC_VEC_TMR0;
	assign vec_tab[3] = `TLVIC_VEC_TWI;
	assign vec_tab[4] = `TLVIC_VEC_EXT1;
	assign vec_tab[5] = `TLVIC_VEC_DDC;
	assign vec_tab[6] = `TLVIC_VEC_TMR1;
	assign vec_tab[7] = `TLVIC_VEC_USB;
	assign vec_tab[8] = `TLVIC_VEC_SER1;
	assign vec_tab[9] = `TLVIC_VEC_TMR2;

	// gating per source
	genvar gi;
	generate
		for (gi = 0; gi < `TLVIC_NUM_SRC; gi++)
		begin : g_gate
			assign act[gi] = st.sample[gi] & en_map[gi] & st.pri_en[`TLVIC_GLOBAL_BIT];
			assign hi_req[gi] = act[gi] & lvl_map[gi];
			assign lo_req[gi] = act[gi] & ~lvl_map[gi];
		end
	endgenerate

	// next state: registers, sample, poll and in-progress tracking
	always_comb
	begin
		logic       blocked;
		logic       take;
		logic       take_hi;
		logic [9:0] pick;
		next_st = st;
		blocked = 1'b0;
		take = 1'b0;
		take_hi = 1'b0;
		pick = '0;
		next_st.call = 1'b0;
		// register writes, reserved bits forced to zero
		if (reg_wr_i)
		begin
			case (reg_addr_i)
				`TLVIC_ADDR_SEC_EN:  next_st.sec_en  = reg_wdata_i & `TLVIC_MASK_SEC;
				`TLVIC_ADDR_PRI_EN:  next_st.pri_en  = reg_wdata_i & `TLVIC_MASK_PRI_EN;
				`TLVIC_ADDR_SEC_LVL: next_st.sec_lvl = reg_wdata_i & `TLVIC_MASK_SEC;
				`TLVIC_ADDR_PRI_LVL: next_st.pri_lvl = reg_wdata_i & `TLVIC_MASK_PRI_LVL;
				default: ;
			endcase
		end
		// read data; unmapped addresses read zero
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				`TLVIC_ADDR_SEC_EN:  next_st.rdata = st.sec_en;
				`TLVIC_ADDR_PRI_EN:  next_st.rdata = st.pri_en;
				`TLVIC_ADDR_SEC_LVL: next_st.rdata = st.sec_lvl;
				`TLVIC_ADDR_PRI_LVL: next_st.rdata = st.pri_lvl;
				default:             next_st.rdata = 8'h00;
			endcase
		end
		// snapshot only; overwritten at every sample strobe so nothing is remembered
		if (sample_i)
			next_st.sample = raw;
		// high wins, then lowest index within a level
		if (|hi_req)
		begin
			pick = hi_req & (~hi_req + 10'h001);
			take_hi = 1'b1;
		end
		else
			pick = lo_req & (~lo_req + 10'h001);
		// blocked by equal/higher routine, mid instruction, return or register access
		blocked = st.in_prog[1]
			| (st.in_prog[0] & ~take_hi)
			| ~final_cycle_i | return_from_irq_i | reg_access_i | reg_wr_i;
		take = poll_i & (|pick) & ~blocked;
		if (take)
		begin
			next_st.call = 1'b1;
			for (int i = 0; i < `TLVIC_NUM_SRC; i++)
			begin
				if (pick[i])
				begin
					next_st.vector = vec_tab[i];
					next_st.src = 4'(i);
				end
			end
			if (take_hi)
				next_st.in_prog[1] = 1'b1;
			else
				next_st.in_prog[0] = 1'b1;
		end
		else if (return_from_irq_i)
		begin
			// return clears the highest active level only
			if (st.in_prog[1])
				next_st.in_prog[1] = 1'b0;
			else
				next_st.in_prog[0] = 1'b0;
		end
	end

	// single state register
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			st <= '0;
			st.sec_en <= `TLVIC_RESET_VAL;
			st.pri_en <= `TLVIC_RESET_VAL;
			st.sec_lvl <= `TLVIC_RESET_VAL;
			st.pri_lvl <= `TLVIC_RESET_VAL;
		end
		else
			st <= next_st;
	end

	// outputs straight from flops
	assign reg_rdata_o = st.rdata;
	assign long_call_o = st.call;
	assign vector_o = st.vector;
	assign src_o = st.src;
	assign in_prog_o = st.in_prog;
endmodule

// ==== test/tlvic_core_mdl.sv ====
// core sequencer model: machine-cycle sample and poll strobes
// assumes a four-clock machine cycle is close enough for the controller
`timescale 1ns/100ps
module tlvic_core_mdl (
	input  wire logic clk_i,
	input  wire logic nrst_i,
	output logic      sample_o,
	output logic      poll_o
);
	logic [1:0] ph;
	// phase counter, restarts with reset so the first sample leads the first poll
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			ph <= 2'h0;
		else
			ph <= ph + 2'h1;
	end
	// one sample per machine cycle, polled half a cycle later
	assign sample_o = nrst_i && ph == 2'h0;
	assign poll_o = nrst_i && ph == 2'h2;
endmodule

// ==== test/tlvic_ctrl_chk.sv ====
// port assertions of the interrupt controller
// assumes it is bound to tlvic_ctrl below
`timescale 1ns/100ps
module tlvic_ctrl_chk (
	input wire logic        clk_i,
	input wire logic        nrst_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic        poll_i,
	input wire logic        final_cycle_i,
	input wire logic        return_from_irq_i,
	input wire logic        reg_access_i,
	input wire logic        long_call_o,
	input wire logic [15:0] vector_o,
	input wire logic [3:0]  src_o,
	input wire logic [1:0]  in_prog_o
);
	logic [3:0] slot;
	// vector slot: even poll index counts up, odd ones count down from nine
	assign slot = src_o[0] ? 4'h9 - {1'h0, src_o[3:1]} : {1'h0, src_o[3:1]};
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	// a cycle in which no call may be launched
	sequence s_blocked;
		!poll_i || !final_cycle_i || return_from_irq_i || reg_access_i || reg_wr_i;
	endsequence
	// a return not masked by a same-cycle call
	sequence s_return;
		return_from_irq_i && !poll_i;
	endsequence
	call_pulse_a: assert property (long_call_o |=> !long_call_o)
		else $error("call longer than one cycle");
	call_cause_a: assert property (s_blocked |=> !long_call_o)
		else $error("call without a clean poll");
	high_block_a: assert property (long_call_o |-> !$past(in_prog_o[1]))
		else $error("call during high routine");
	low_preempt_a: assert property (long_call_o && $past(in_prog_o[0]) |-> in_prog_o[1])
		else $error("equal level call in low routine");
	level_set_a: assert property (long_call_o |->
		$countones(in_prog_o) == $countones($past(in_prog_o)) + 1)
		else $error("call did not open one level");
	vector_map_a: assert property (long_call_o |-> vector_o == {9'h000, slot, 3'h3})
		else $error("wrong vector for source");
	ret_clear_a: assert property (s_return |=>
		in_prog_o == ($past(in_prog_o[1]) ? ($past(in_prog_o) & 2'h1) : 2'h0))
		else $error("return cleared wrong level");
	resv_zero_a: assert property (reg_rd_i && reg_addr_i == 8'hb8 |=> reg_rdata_o[7:6] == 2'h0)
		else $error("reserved level bits set");
endmodule
bind tlvic_ctrl tlvic_ctrl_chk u_tlvic_ctrl_chk (.*);

// ==== test/tlvic_ctrl_tb_top.sv ====
// self-checking bench of the interrupt controller
// assumes tlvic_core_mdl makes the strobes; the bench plays software and flags
`timescale 1ns/100ps
module tlvic_ctrl_tb_top;
	logic        clk_i = 1'b0, nrst_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic        final_cycle_i = 1'b1, return_from_irq_i = 1'b0, reg_access_i = 1'b0;
	logic        alt = 1'b0, sample_i, poll_i, long_call_o;
	logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
	logic [9:0]  rq = 10'h000;
	logic [5:0]  ub = 6'h01;
	logic [15:0] vector_o;
	logic [3:0]  src_o;
	logic [1:0]  in_prog_o;
	logic [7:0]  adr [4] = '{8'ha7, 8'ha8, 8'hb7, 8'hb8};
	logic [7:0]  msk [4] = '{8'h93, 8'hbf, 8'h93, 8'h3f};
	int          cmp_count = 0, n_mismatch = 0;
	// request flags in poll order; alt picks transmit and external flags
	wire ext_pin0_request_i = rq[0], timer0_flag_i = rq[2], twowire_flag_i = rq[3];
	wire ext_pin1_request_i = rq[4], display_data_channel_i = rq[5], timer1_flag_i = rq[6];
	wire ser2_rx_complete_flag_i = rq[1] & !alt, ser2_tx_complete_flag_i = rq[1] & alt;
	wire ser1_rx_complete_flag_i = rq[8] & !alt, ser1_tx_complete_flag_i = rq[8] & alt;
	wire timer2_flag_i = rq[9] & !alt, timer2_ext_flag_i = rq[9] & alt;
	wire [5:0] usb_event_i = rq[7] ? ub : 6'h00;
	tlvic_ctrl u_tlvic_ctrl (.*);
	tlvic_core_mdl u_tlvic_core_mdl (.clk_i, .nrst_i, .sample_o(sample_i), .poll_o(poll_i));
	initial
		forever #4 clk_i = ~clk_i;
	task chk(input logic [15:0] g, input logic [15:0] x);
		cmp_count++;
		if (g !== x)
		begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, g, x);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk({8'h00, reg_rdata_o}, {8'h00, x});
	endtask
	// raise flags before a sample, judge the poll after it; 10 means no call
	task go(input logic [9:0] r, input logic [4:0] e);
		@(posedge clk_i iff poll_i);
		rq <= r;
		@(posedge clk_i iff poll_i);
		// the call pulse stands only in the cycle after the poll edge
		rq <= 10'h000;
		#1;
		chk({15'h0000, long_call_o}, {15'h0000, e != 5'h10});
		if (e != 5'h10)
			chk({12'h000, src_o}, {11'h000, e});
	endtask
	task ret;
		@(posedge clk_i);
		return_from_irq_i <= 1'b1;
		@(posedge clk_i);
		return_from_irq_i <= 1'b0;
	endtask
	task gr(input logic [9:0] r, input logic [4:0] e);
		go(r, e);
		ret;
	endtask
	task end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// watchdog, well beyond the few hundred cycles the run needs
	initial
	begin
		#60000;
		n_mismatch++;
		end_of_test;
	end
	initial
	begin
		repeat (8) @(posedge clk_i);
		nrst_i <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			rd(adr[i], 8'h00);
			wr(adr[i], 8'hff);
			rd(adr[i], msk[i]);
		end
		rd(8'ha9, 8'h00);
		wr(8'hb7, 8'h00);
		wr(8'hb8, 8'h00);
		wr(8'ha8, 8'h3f);
		go(10'h3ff, 5'h10);
		wr(8'ha8, 8'hbf);
		for (int i = 0; i < 10; i++)
			gr(10'h3ff << i, i[4:0]);
		wr(8'ha8, 8'hbe);
		go(10'h001, 5'h10);
		wr(8'ha8, 8'hbf);
		wr(8'hb8, 8'h10);
		go(10'h3ff, 5'h08);
		go(10'h3ff, 5'h10);
		ret;
		go(10'h001, 5'h00);
		go(10'h002, 5'h10);
		go(10'h100, 5'h08);
		go(10'h001, 5'h10);
		ret;
		ret;
		@(posedge clk_i);
		final_cycle_i <= 1'b0;
		go(10'h001, 5'h10);
		@(posedge clk_i);
		final_cycle_i <= 1'b1;
		reg_access_i <= 1'b1;
		go(10'h001, 5'h10);
		@(posedge clk_i);
		reg_access_i <= 1'b0;
		go(10'h000, 5'h10);
		for (int k = 0; k < 6; k++)
		begin
			@(posedge clk_i);
			ub <= 6'h01 << k;
			gr(10'h080, 5'h07);
		end
		@(posedge clk_i);
		alt <= 1'b1;
		gr(10'h100, 5'h08);
		gr(10'h200, 5'h09);
		gr(10'h002, 5'h01);
		wr(8'ha7, 8'h83);
		go(10'h002, 5'h10);
		end_of_test;
	end
endmodule
